/* logic/fifo_cfg_if.sv */
/*
  Carrier between the register side and the FIFO sizing decoder.
  Assumes both ends run on the same clock; the decoder is combinational.
*/
`timescale 1ns/10ps
`default_nettype none
interface fifo_cfg_if;
  logic fifo_enable;
  logic rx_byte_usage_select;
  logic [1:0] duplex_mode;
  logic [1:0] rx_fill_level;
  logic [2:0] rx_depth;
  logic [2:0] tx_depth;
  logic [2:0] rx_used;
  modport ctrl (output fifo_enable, rx_byte_usage_select, duplex_mode, rx_fill_level,
                input rx_depth, tx_depth, rx_used);
  modport sizer (input fifo_enable, rx_byte_usage_select, duplex_mode, rx_fill_level,
                 output rx_depth, tx_depth, rx_used);
endinterface
`default_nettype wire

/* logic/fifo_sizer.sv */
/*
  FIFO sizing decoder: depths from duplex mode, receive bytes in use from
  the byte usage select and the receive fill level.
  Assumes its inputs are registered on the caller's clock.
*/
`timescale 1ns/10ps
`default_nettype none
module fifo_sizer
  import serial_fifo_pkg::*;
(
  // Configuration in, sizes out
  fifo_cfg_if.sizer cfg
);

  // Receive fill level in bytes for the given duplex mode
  function automatic logic [2:0] fill_bytes(input logic [1:0] lvl, input logic full);
    logic [2:0] b;
    b = 3'h0;
    unique case (lvl)
      2'h0: b = full ? 3'h2 : 3'h4;
      2'h1: b = 3'h1;
      2'h2: b = 3'h2;
      2'h3: b = full ? 3'h1 : 3'h3;
    endcase
    return b;
  endfunction

  // Depth per direction, zero while FIFOs are off
  always_comb begin
    cfg.rx_depth = DEPTH_NONE;
    cfg.tx_depth = DEPTH_NONE;
    if (cfg.fifo_enable) begin
      unique case (cfg.duplex_mode)
        DUPLEX_HALF_RX: cfg.rx_depth = DEPTH_HALF;
        DUPLEX_HALF_TX: cfg.tx_depth = DEPTH_HALF;
        DUPLEX_FULL: begin
          cfg.rx_depth = DEPTH_FULL;
          cfg.tx_depth = DEPTH_FULL;
        end
        DUPLEX_NONE: begin
          cfg.rx_depth = DEPTH_NONE;
        end
      endcase
    end
  end

  // Receive bytes used: full depth or fill level
  always_comb begin
    cfg.rx_used = cfg.rx_depth;
    if (cfg.fifo_enable && cfg.rx_byte_usage_select && cfg.rx_depth != DEPTH_NONE) begin
      cfg.rx_used = fill_bytes(cfg.rx_fill_level, cfg.duplex_mode == DUPLEX_FULL);
    end
  end

endmodule
`default_nettype wire

/* logic/serial_fifo_config.sv */
/*
  FIFO configuration logic of a serial channel with an AHB-Lite register
  slave, sticky interrupt status with mask, FIFO sizing and automatic
  clearing of the transmit and receive enables.
  Assumes all channel inputs come from logic on hclk; zero-wait bus slave.
*/
// Our own choices: the address map and the AHB-Lite interface to the registers.
// Contract
// - Transmit FIFO interrupts gated by transmit enable bit
// - Receive FIFO interrupts gated by receive enable bit
// - Half-duplex receive: auto-clear receive enable when full
// - Half-duplex transmit: auto-clear transmit enable when drained
// - Full duplex: either condition clears both enables
// - Duplex mode sizes FIFOs: 4, 4, 2+2 bytes
// - Transmit FIFO always offers full configured depth
`timescale 1ns/10ps
`default_nettype none
module serial_fifo_config
  import serial_fifo_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Channel mode and fill level
  input wire logic [1:0] duplex_mode,
  input wire logic [1:0] rx_fill_level,
  // Channel state
  input wire logic [2:0] rx_fifo_count,
  input wire logic [2:0] tx_fifo_count,
  input wire logic rx_shift_full,
  input wire logic rx_buffer_full,
  input wire logic tx_buffer_empty,
  input wire logic rx_irq_request,
  input wire logic tx_irq_request,
  // FIFO sizing
  output logic [2:0] rx_fifo_depth,
  output logic [2:0] tx_fifo_depth,
  output logic [2:0] rx_bytes_used,
  // Gated interrupts and enable clears
  output logic rx_fifo_irq,
  output logic tx_fifo_irq,
  output logic rx_enable_clear,
  output logic tx_enable_clear,
  output logic irq
);

  fifo_cfg_if cfg_bus ();

  logic [7:0] fifo_configuration_r, fifo_configuration_nxt;
  logic [3:0] irq_mask_r, irq_mask_nxt;
  logic [3:0] irq_status_r, irq_status_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [2:0] rx_depth_r, tx_depth_r, rx_used_r;
  logic rx_irq_r, tx_irq_r, rx_clr_r, tx_clr_r, irq_r, hreadyout_r;
  logic hresp_r;
  logic rx_irq_nxt, tx_irq_nxt, rx_clr_nxt, tx_clr_nxt, irq_nxt;
  logic rx_full_cond, tx_drained_cond, auto_on;
  logic [3:0] events;

  // Accepted address phase of a transfer
  function automatic logic addr_phase(input logic sel, input logic [1:0] tr, input logic rdy);
    return sel && rdy && (tr == HTRANS_NONSEQ || tr == HTRANS_SEQ);
  endfunction

  fifo_sizer u_sizer (
    .cfg (cfg_bus.sizer)
  );

  // Configuration onto the carrier
  assign cfg_bus.fifo_enable = fifo_configuration_r[CFG_FIFO_ENABLE];
  assign cfg_bus.rx_byte_usage_select = fifo_configuration_r[CFG_RX_BYTE_USAGE_SELECT];
  assign cfg_bus.duplex_mode = duplex_mode;
  assign cfg_bus.rx_fill_level = rx_fill_level;

  // Bus write path and read mux, write data forwarded to a following read
  always_comb begin
    fifo_configuration_nxt = fifo_configuration_r;
    irq_mask_nxt = irq_mask_r;
    wr_pend_nxt = addr_phase(hsel, htrans, hready) && hwrite;
    wr_addr_nxt = addr_phase(hsel, htrans, hready) ? haddr[7:0] : wr_addr_r;
    if (wr_pend_r && wr_addr_r == OFS_FIFO_CONFIGURATION) begin
      fifo_configuration_nxt = hwdata[7:0];
    end
    if (wr_pend_r && wr_addr_r == OFS_IRQ_MASK) begin
      irq_mask_nxt = hwdata[3:0];
    end
    hrdata_nxt = hrdata_r;
    if (addr_phase(hsel, htrans, hready) && !hwrite) begin
      hrdata_nxt = 32'h0000_0000;
      unique case (haddr[7:0])
        OFS_FIFO_CONFIGURATION: hrdata_nxt[7:0] = fifo_configuration_nxt;
        OFS_IRQ_STATUS: hrdata_nxt[3:0] = irq_status_r;
        OFS_IRQ_MASK: hrdata_nxt[3:0] = irq_mask_nxt;
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fifo_configuration_r <= CFG_RESET;
      irq_mask_r <= IRQ_RESET;
      hrdata_r <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hreadyout_r <= 1'b1;
      hresp_r <= HRESP_OKAY;
    end else begin
      fifo_configuration_r <= fifo_configuration_nxt;
      irq_mask_r <= irq_mask_nxt;
      hrdata_r <= hrdata_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hreadyout_r <= 1'b1;
      hresp_r <= HRESP_OKAY;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;

  // Channel conditions and gated interrupts, outputs from flops
  always_comb begin
    auto_on = fifo_configuration_r[CFG_FIFO_ENABLE]
              && fifo_configuration_r[CFG_AUTO_ENABLE_CLEAR];
    rx_full_cond = rx_shift_full && rx_buffer_full && rx_fifo_count >= cfg_bus.rx_used;
    tx_drained_cond = tx_fifo_count == 3'h0 && tx_buffer_empty;
    rx_clr_nxt = 1'b0;
    tx_clr_nxt = 1'b0;
    if (auto_on) begin
      unique case (duplex_mode)
        DUPLEX_HALF_RX: rx_clr_nxt = rx_full_cond;
        DUPLEX_HALF_TX: tx_clr_nxt = tx_drained_cond;
        DUPLEX_FULL: begin
          rx_clr_nxt = rx_full_cond || tx_drained_cond;
          tx_clr_nxt = rx_full_cond || tx_drained_cond;
        end
        DUPLEX_NONE: rx_clr_nxt = 1'b0;
      endcase
    end
    rx_irq_nxt = rx_irq_request && cfg_bus.rx_depth != DEPTH_NONE
                 && fifo_configuration_r[CFG_RX_FIFO_IRQ_ENABLE];
    tx_irq_nxt = tx_irq_request && cfg_bus.tx_depth != DEPTH_NONE
                 && fifo_configuration_r[CFG_TX_FIFO_IRQ_ENABLE];
  end

  // Sticky status: read clears, a new event wins over the clear
  always_comb begin
    events = '0;
    events[IRQ_RX_FIFO] = rx_irq_nxt;
    events[IRQ_TX_FIFO] = tx_irq_nxt;
    events[IRQ_RX_AUTO_CLEAR] = rx_clr_nxt;
    events[IRQ_TX_AUTO_CLEAR] = tx_clr_nxt;
    irq_status_nxt = irq_status_r;
    if (addr_phase(hsel, htrans, hready) && !hwrite && haddr[7:0] == OFS_IRQ_STATUS) begin
      irq_status_nxt = IRQ_RESET;
    end
    for (int i = 0; i < IRQ_WIDTH; i++) begin
      if (events[i]) begin
        irq_status_nxt[i] = 1'b1;
      end
    end
    irq_nxt = |(irq_status_nxt & irq_mask_nxt);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_r <= IRQ_RESET;
      rx_depth_r <= DEPTH_NONE;
      tx_depth_r <= DEPTH_NONE;
      rx_used_r <= DEPTH_NONE;
      rx_irq_r <= 1'b0;
      tx_irq_r <= 1'b0;
      rx_clr_r <= 1'b0;
      tx_clr_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      irq_status_r <= irq_status_nxt;
      rx_depth_r <= cfg_bus.rx_depth;
      tx_depth_r <= cfg_bus.tx_depth;
      rx_used_r <= cfg_bus.rx_used;
      rx_irq_r <= rx_irq_nxt;
      tx_irq_r <= tx_irq_nxt;
      rx_clr_r <= rx_clr_nxt;
      tx_clr_r <= tx_clr_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign rx_fifo_depth = rx_depth_r;
  assign tx_fifo_depth = tx_depth_r;
  assign rx_bytes_used = rx_used_r;
  assign rx_fifo_irq = rx_irq_r;
  assign tx_fifo_irq = tx_irq_r;
  assign rx_enable_clear = rx_clr_r;
  assign tx_enable_clear = tx_clr_r;
  assign irq = irq_r;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence cfg_read_s;
    addr_phase(hsel, htrans, hready) && !hwrite && haddr[7:0] == OFS_FIFO_CONFIGURATION;
  endsequence

  sequence cfg_write_s;
    addr_phase(hsel, htrans, hready) && hwrite && haddr[7:0] == OFS_FIFO_CONFIGURATION
    ##1 1'b1;
  endsequence

  cfg_upper_zero_a: assert property (cfg_read_s |=> hrdata[31:8] == 24'h000000)
    else $error("configuration read upper bits not zero");
  cfg_write_store_a: assert property (cfg_write_s
    |=> fifo_configuration_r == $past(hwdata[7:0]))
    else $error("configuration write not stored");
  rx_used_sel_a: assert property (!fifo_configuration_r[CFG_RX_BYTE_USAGE_SELECT]
    && $stable(fifo_configuration_r) |=> rx_bytes_used == rx_fifo_depth)
    else $error("receive bytes used differ from depth");
  tx_irq_gate_a: assert property (tx_fifo_irq |-> $past(tx_irq_request)
    && $past(fifo_configuration_r[CFG_TX_FIFO_IRQ_ENABLE]))
    else $error("transmit FIFO interrupt not gated");
  rx_irq_gate_a: assert property (rx_fifo_irq |-> $past(rx_irq_request)
    && $past(fifo_configuration_r[CFG_RX_FIFO_IRQ_ENABLE]))
    else $error("receive FIFO interrupt not gated");
  rx_auto_clear_a: assert property (auto_on && duplex_mode == DUPLEX_HALF_RX
    && rx_full_cond |=> rx_enable_clear && !tx_enable_clear)
    else $error("receive enable not cleared");
  tx_auto_clear_a: assert property (auto_on && duplex_mode == DUPLEX_HALF_TX
    && tx_drained_cond |=> tx_enable_clear && !rx_enable_clear)
    else $error("transmit enable not cleared");
  full_auto_clear_a: assert property (auto_on && duplex_mode == DUPLEX_FULL
    && (rx_full_cond || tx_drained_cond) |=> rx_enable_clear && tx_enable_clear)
    else $error("full duplex enables not cleared");
  no_auto_clear_a: assert property (!auto_on |=> !rx_enable_clear && !tx_enable_clear)
    else $error("enable cleared without auto disable");
  half_depth_a: assert property (fifo_configuration_r[CFG_FIFO_ENABLE]
    && duplex_mode == DUPLEX_HALF_RX |=> rx_fifo_depth == 3'h4 && tx_fifo_depth == 3'h0)
    else $error("half duplex receive depth wrong");
  full_depth_a: assert property (fifo_configuration_r[CFG_FIFO_ENABLE]
    && duplex_mode == DUPLEX_FULL |=> rx_fifo_depth == 3'h2 && tx_fifo_depth == 3'h2)
    else $error("full duplex depths wrong");
  tx_depth_full_a: assert property (fifo_configuration_r[CFG_FIFO_ENABLE]
    && duplex_mode == DUPLEX_HALF_TX |=> tx_fifo_depth == 3'h4)
    else $error("transmit depth not full");
  fifo_off_a: assert property (!fifo_configuration_r[CFG_FIFO_ENABLE]
    |=> rx_fifo_depth == 3'h0 && tx_fifo_depth == 3'h0 && !rx_fifo_irq && !tx_fifo_irq)
    else $error("FIFO behaviour while disabled");

  sequence status_read_s;
    addr_phase(hsel, htrans, hready) && !hwrite && haddr[7:0] == OFS_IRQ_STATUS;
  endsequence

  // Zero-wait slave, always OKAY
  bus_resp_a: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("bus response not ready or not okay");

  // Read data comes from the register addressed
  cfg_read_data_a: assert property (cfg_read_s
    |=> hrdata[7:0] == fifo_configuration_r)
    else $error("configuration read data wrong");
  status_read_data_a: assert property (status_read_s
    |=> hrdata == {28'h0000000, $past(irq_status_r)})
    else $error("status read data wrong");

  // Read clears status, but an event in the same cycle still sets its bit
  status_clear_a: assert property (status_read_s ##0 events == 4'h0
    |=> irq_status_r == IRQ_RESET)
    else $error("status not cleared by read");
  status_set_a: assert property (events != 4'h0
    |=> (irq_status_r & $past(events)) == $past(events))
    else $error("status event lost");
  irq_level_a: assert property (irq == |(irq_status_r & irq_mask_r))
    else $error("interrupt level wrong");

  // Each gated output leaves its sticky status bit set
  rx_irq_status_a: assert property (rx_fifo_irq |-> irq_status_r[IRQ_RX_FIFO])
    else $error("receive FIFO interrupt not recorded");
  tx_irq_status_a: assert property (tx_fifo_irq |-> irq_status_r[IRQ_TX_FIFO])
    else $error("transmit FIFO interrupt not recorded");
  rx_clr_status_a: assert property (rx_enable_clear
    |-> irq_status_r[IRQ_RX_AUTO_CLEAR])
    else $error("receive enable clear not recorded");
  tx_clr_status_a: assert property (tx_enable_clear
    |-> irq_status_r[IRQ_TX_AUTO_CLEAR])
    else $error("transmit enable clear not recorded");

  // Receive bytes in use never exceed the configured depth
  rx_used_range_a: assert property (rx_fifo_depth != DEPTH_NONE
    |-> rx_bytes_used != DEPTH_NONE && rx_bytes_used <= rx_fifo_depth)
    else $error("receive bytes used out of range");

endmodule
`default_nettype wire

/* logic/serial_fifo_pkg.sv */
/*
  Shared constants of the serial FIFO configuration block: register map,
  field positions, duplex codes, FIFO depths and interrupt status layout.
  Assumes a 32-bit word-aligned register bus and 3-bit byte counts.
*/
`default_nettype none
package serial_fifo_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_FIFO_CONFIGURATION = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  // Configuration field positions
  localparam int CFG_FIFO_ENABLE = 0;
  localparam int CFG_AUTO_ENABLE_CLEAR = 1;
  localparam int CFG_RX_FIFO_IRQ_ENABLE = 2;
  localparam int CFG_TX_FIFO_IRQ_ENABLE = 3;
  localparam int CFG_RX_BYTE_USAGE_SELECT = 4;
  localparam int CFG_WIDTH = 8;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Interrupt status layout
  localparam int IRQ_RX_FIFO = 0;
  localparam int IRQ_TX_FIFO = 1;
  localparam int IRQ_RX_AUTO_CLEAR = 2;
  localparam int IRQ_TX_AUTO_CLEAR = 3;
  localparam int IRQ_WIDTH = 4;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  // Duplex mode codes
  localparam logic [1:0] DUPLEX_NONE = 2'h0;
  localparam logic [1:0] DUPLEX_HALF_RX = 2'h1;
  localparam logic [1:0] DUPLEX_HALF_TX = 2'h2;
  localparam logic [1:0] DUPLEX_FULL = 2'h3;
  // FIFO depths in bytes
  localparam logic [2:0] DEPTH_NONE = 3'h0;
  localparam logic [2:0] DEPTH_HALF = 3'h4;
  localparam logic [2:0] DEPTH_FULL = 3'h2;
  // AHB transfer type and response
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;
endpackage
`default_nettype wire

/* tb/tb_top.sv */
/*
  Self-checking bench for the serial FIFO configuration block.
  Assumes a zero-wait AHB-Lite slave and channel outputs registered one edge.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import serial_fifo_pkg::*;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0, duplex_mode = 2'h0, rx_fill_level = 2'h0;
  logic [2:0] hsize = 3'h2, rx_fifo_count = 3'h0, tx_fifo_count = 3'h1;
  logic rx_shift_full = 1'h0, rx_buffer_full = 1'h0, tx_buffer_empty = 1'h0;
  logic rx_irq_request = 1'h0, tx_irq_request = 1'h0;
  logic hreadyout, hresp, rx_fifo_irq, tx_fifo_irq, rx_enable_clear, tx_enable_clear, irq;
  logic [31:0] hrdata;
  logic [2:0] rx_fifo_depth, tx_fifo_depth, rx_bytes_used;
  wire logic hready;
  wire logic [31:0] outs;
  int n_mismatch = 0, checked = 0, cycles = 0;
  // Expected depths per duplex code, receive bytes used with select on
  logic [2:0] rxd[4] = '{3'h0, 3'h4, 3'h0, 3'h2};
  logic [2:0] txd[4] = '{3'h0, 3'h0, 3'h4, 3'h2};
  logic [2:0] used1[8] = '{3'h4, 3'h1, 3'h2, 3'h3, 3'h2, 3'h1, 3'h2, 3'h1};

  // One slave, so its ready is the bus ready
  assign hready = hreadyout;
  // Packed view of the channel outputs
  assign outs = {16'h0, irq, rx_enable_clear, tx_enable_clear, rx_fifo_irq, tx_fifo_irq,
                 2'h0, rx_fifo_depth, tx_fifo_depth, rx_bytes_used};

  serial_fifo_config serial_fifo_config_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .duplex_mode(duplex_mode), .rx_fill_level(rx_fill_level),
    .rx_fifo_count(rx_fifo_count), .tx_fifo_count(tx_fifo_count),
    .rx_shift_full(rx_shift_full), .rx_buffer_full(rx_buffer_full),
    .tx_buffer_empty(tx_buffer_empty), .rx_irq_request(rx_irq_request),
    .tx_irq_request(tx_irq_request), .rx_fifo_depth(rx_fifo_depth),
    .tx_fifo_depth(tx_fifo_depth), .rx_bytes_used(rx_bytes_used),
    .rx_fifo_irq(rx_fifo_irq), .tx_fifo_irq(tx_fifo_irq),
    .rx_enable_clear(rx_enable_clear), .tx_enable_clear(tx_enable_clear), .irq(irq)
  );

  // Clock, 10 ns period
  always #5 hclk = ~hclk;

  // Hang guard
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      summarize();
    end
  end

  // Expected packed outputs: flags are irq, rx clear, tx clear, rx irq, tx irq
  function automatic logic [31:0] ex(input logic [4:0] f, input logic [2:0] r,
                                     input logic [2:0] t, input logic [2:0] u);
    return {16'h0, f, 2'h0, r, t, u};
  endfunction

  task automatic summarize();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // Single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(what, exp, q);
    chk("response", {30'h0, 1'h1, HRESP_OKAY}, {30'h0, hreadyout, hresp});
  endtask

  // Let registered outputs follow their inputs
  task automatic settle();
    repeat (3) @(posedge hclk);
    #1;
  endtask

  // Channel state: receive full, receive count, transmit drained
  task automatic chan(input logic [1:0] dup, input logic [1:0] fill, input logic rf,
                      input logic [2:0] rc, input logic td);
    @(posedge hclk);
    duplex_mode <= dup;
    rx_fill_level <= fill;
    rx_shift_full <= rf;
    rx_buffer_full <= rf;
    rx_fifo_count <= rc;
    tx_fifo_count <= td ? 3'h0 : 3'h1;
    tx_buffer_empty <= td;
  endtask

  task automatic req(input logic [1:0] r);
    @(posedge hclk);
    rx_irq_request <= r[1];
    tx_irq_request <= r[0];
  endtask

  // Apply a clear condition, check outputs, remove it, check sticky status
  task automatic ac(input logic [1:0] dup, input logic rf, input logic [2:0] rc,
                    input logic td, input logic [31:0] eo, input logic [31:0] es);
    chan(dup, 2'h0, rf, rc, td);
    settle();
    chk("outs", eo, outs);
    chan(dup, 2'h0, 1'h0, 3'h0, 1'h0);
    settle();
    rd("status", OFS_IRQ_STATUS, es);
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    rd("config", OFS_FIFO_CONFIGURATION, 32'h0);
    rd("status", OFS_IRQ_STATUS, 32'h0);
    rd("mask", OFS_IRQ_MASK, 32'h0);
    wr(OFS_FIFO_CONFIGURATION, 32'hFFFF_FF1F);
    rd("config", OFS_FIFO_CONFIGURATION, 32'h0000_001F);
    rd("unmapped", 8'h0C, 32'h0);
    done("registers");
    for (int m = 0; m < 4; m++) begin
      chan(m[1:0], 2'h0, 1'h0, 3'h0, 1'h0);
      wr(OFS_FIFO_CONFIGURATION, 32'h0000_0010);
      settle();
      chk("outs", ex(5'h0, 3'h0, 3'h0, 3'h0), outs);
      wr(OFS_FIFO_CONFIGURATION, 32'h0000_0001);
      settle();
      chk("outs", ex(5'h0, rxd[m], txd[m], rxd[m]), outs);
    end
    done("sizing");
    wr(OFS_FIFO_CONFIGURATION, 32'h0000_0011);
    for (int f = 0; f < 8; f++) begin
      int x;
      x = f[2] ? 3 : 1;
      chan(f[2] ? DUPLEX_FULL : DUPLEX_HALF_RX, f[1:0], 1'h0, 3'h0, 1'h0);
      settle();
      chk("outs", ex(5'h0, rxd[x], txd[x], used1[f]), outs);
    end
    done("byte usage");
    chan(DUPLEX_FULL, 2'h0, 1'h0, 3'h0, 1'h0);
    wr(OFS_FIFO_CONFIGURATION, 32'h0000_0001);
    wr(OFS_IRQ_MASK, 32'h0000_0002);
    rd("status", OFS_IRQ_STATUS, 32'h0);
    req(2'h3);
    settle();
    chk("outs", ex(5'h00, 3'h2, 3'h2, 3'h2), outs);
    req(2'h0);
    rd("status", OFS_IRQ_STATUS, 32'h0);
    wr(OFS_FIFO_CONFIGURATION, 32'h0000_000D);
    req(2'h1);
    settle();
    chk("outs", ex(5'h11, 3'h2, 3'h2, 3'h2), outs);
    req(2'h2);
    settle();
    chk("outs", ex(5'h12, 3'h2, 3'h2, 3'h2), outs);
    req(2'h0);
    rd("status", OFS_IRQ_STATUS, 32'h0000_0003);
    settle();
    chk("outs", ex(5'h00, 3'h2, 3'h2, 3'h2), outs);
    wr(OFS_IRQ_MASK, 32'h0);
    req(2'h2);
    settle();
    chk("outs", ex(5'h02, 3'h2, 3'h2, 3'h2), outs);
    req(2'h0);
    rd("status", OFS_IRQ_STATUS, 32'h0000_0001);
    wr(OFS_FIFO_CONFIGURATION, 32'h0000_001C);
    req(2'h3);
    settle();
    chk("outs", ex(5'h00, 3'h0, 3'h0, 3'h0), outs);
    req(2'h0);
    rd("status", OFS_IRQ_STATUS, 32'h0);
    done("interrupts");
    wr(OFS_FIFO_CONFIGURATION, 32'h0000_0003);
    wr(OFS_IRQ_MASK, 32'h0000_000C);
    ac(DUPLEX_HALF_RX, 1'h1, 3'h4, 1'h1, ex(5'h18, 3'h4, 3'h0, 3'h4), 32'h4);
    ac(DUPLEX_HALF_RX, 1'h1, 3'h3, 1'h0, ex(5'h00, 3'h4, 3'h0, 3'h4), 32'h0);
    ac(DUPLEX_HALF_TX, 1'h1, 3'h4, 1'h1, ex(5'h14, 3'h0, 3'h4, 3'h0), 32'h8);
    ac(DUPLEX_FULL, 1'h0, 3'h0, 1'h1, ex(5'h1C, 3'h2, 3'h2, 3'h2), 32'hC);
    ac(DUPLEX_FULL, 1'h1, 3'h2, 1'h0, ex(5'h1C, 3'h2, 3'h2, 3'h2), 32'hC);
    wr(OFS_FIFO_CONFIGURATION, 32'h0000_0001);
    ac(DUPLEX_FULL, 1'h1, 3'h2, 1'h1, ex(5'h00, 3'h2, 3'h2, 3'h2), 32'h0);
    done("auto clear");
    summarize();
  end
endmodule
`default_nettype wire
